// [common/i2c_port_defines.vh]
// constants for the two-wire bus port block
`ifndef I2C_PORT_DEFINES_VH
`define I2C_PORT_DEFINES_VH
// register word index, byte address = 2 * index
`define A_CON  3'h0
`define A_STAT 3'h1
`define A_RCV  3'h2
`define A_TRN  3'h3
`define A_ADD  3'h4
`define A_BRG  3'h5
// control register fields
`define C_EN   15
`define C_SIDL 13
`define C_REL  12
`define C_ALL  11
`define C_TEN  10
`define C_SLW  9
`define C_SMB  8
`define C_GC   7
`define C_STR  6
`define C_AKV  5
`define C_AKE  4
`define C_RCE  3
`define C_STP  2
`define C_RST  1
`define C_STA  0
`define CON_RST 16'h1000
// status register fields
`define S_AKS 15
`define S_TRS 14
`define S_BCL 10
`define S_GCS 9
`define S_A10 8
`define S_WCO 7
`define S_OV  6
`define S_DA  5
`define S_P   4
`define S_S   3
`define S_RW  2
`define S_RBF 1
`define S_TBF 0
// ten-bit header pattern and general call address
`define TEN_HDR 5'h1e
`define GC_ADDR 8'h00
`endif

// [hdl/i2c_master_slave_port.v]
// two-wire bus master and slave port with avalon register slave
//Function
//[RL1] enable bit hands both pins to the block, clear returns them to port
//[RL2] stop-in-idle freezes the block while the device idles
//[RL3] slave clock release one lets clock go, zero holds it low
//[RL4] with stretch on, release is read/write, cleared at tx start and rx end
//[RL5] with stretch off, software can only set release; cleared at tx start
//[RL6] accept-all mode acknowledges every address
//[RL7] own address is ten-bit when ten-bit select is one, else seven-bit
//[RL8] slew disable bit drives pad slew control output
//[RL9] smbus level bit drives pad threshold select output
//[RL10] general call enable acks general call and pulses interrupt; with accept-all also set, the code acks it with no pulse and no status flag
//[RL11] stretch enable gates software and receive clock stretching
//[RL12] received byte moves shift register to buffer with a pulse
//[RL13] master and slave handle seven and ten bit addressing
//[RL14] master detects collisions and drops the bus on lost arbitration
//[RL15] baud counter reloads from baud reload value to time master clock
//[RL16] standard and fast mode master and slave functions
//[RL17] status low six bits read-only, control fully read/write; code reads control bit 14 back as zero
//[RL18] sixteen-bit register interface
//[RL19] writing transmit register shifts the byte onto the data line
//[RL20] start, restart, stop requests run and self-clear
//[RL21] ack request drives ack value as master receiver, self-clears
//[RL22] rx full sets on load, clears on read; tx full sets on write
//[RL23] open-drain lines, sampled for arbitration and clock sync
//[RL24] byte into full buffer is dropped and sets overflow flag
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "i2c_port_defines.vh"
module i2c_master_slave_port #(
  parameter BRG_W = 9
) (
  input  wire        sys_clk_in,
  input  wire        reset_n_in,
  input  wire [2:0]  address_in,
  input  wire        read_in,
  input  wire        write_in,
  input  wire [15:0] writedata_in,
  output reg  [15:0] readdata_out,
  output reg         waitrequest_out,
  input  wire        idle_mode_in,
  input  wire        scl_in,
  output reg         scl_out,
  output reg         scl_oe_out,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe_out,
  output reg         pins_owned_out,
  output reg         slew_disable_out,
  output reg         smbus_level_out,
  output reg         rx_pulse_out,
  output reg         gc_pulse_out
);
  localparam M_IDLE = 3'h0;
  localparam M_STA  = 3'h1;
  localparam M_RST  = 3'h2;
  localparam M_STP  = 3'h3;
  localparam M_TX   = 3'h4;
  localparam M_RX   = 3'h5;
  localparam M_ACK  = 3'h6;
  localparam S_IDLE = 2'h0;
  localparam S_ADR  = 2'h1;
  localparam S_RX   = 2'h2;
  localparam S_TX   = 2'h3;
  reg [15:0]      con_r;
  reg [15:0]      stat_r;
  reg [7:0]       rcv_r;
  reg [7:0]       trn_r;
  reg [7:0]       rsr_r;
  reg [9:0]       add_r;
  reg [BRG_W-1:0] brg_r;
  reg [BRG_W-1:0] cnt_r;
  reg             scl_q_r;
  reg             sda_q_r;
  reg [2:0]       m_st_r;
  reg [1:0]       mph_r;
  reg [3:0]       mbit_r;
  reg             m_own_r;
  reg             m_scl_r;
  reg             m_sda_r;
  reg [1:0]       s_st_r;
  reg             s_ph2_r;
  reg [3:0]       sbit_r;
  reg             s_ack_r;
  reg [15:0]      rd_nxt;
  reg             sda_nxt;
  reg             m_bit;
  wire en      = con_r[`C_EN];
  wire run     = en & ~(con_r[`C_SIDL] & idle_mode_in);
  wire acc_ok  = ~waitrequest_out;
  wire wr_do   = write_in & acc_ok;
  wire rd_do   = read_in & acc_ok;
  wire rise    = scl_in & ~scl_q_r;
  wire fall    = ~scl_in & scl_q_r;
  wire sta_det = scl_in & scl_q_r & sda_q_r & ~sda_in;
  wire stp_det = scl_in & scl_q_r & ~sda_q_r & sda_in;
  wire [2:0] mix = 3'h7 - mbit_r[2:0];
  wire [2:0] six = 3'h7 - sbit_r[2:0];
  wire tick    = (cnt_r == {BRG_W{1'b0}});
  wire m_hold  = (mph_r == 2'h2) & ~scl_in;
  wire m_busy  = (m_st_r != M_IDLE);
  wire s_on    = en & ~m_own_r;
  wire [7:0] b = rsr_r;
  wire gc_hit  = con_r[`C_GC] & (b == `GC_ADDR);
  wire hdr_hit = (b[7:3] == `TEN_HDR) & (b[2:1] == add_r[9:8]);
  ////////////////////////////////////////////////////////////////
  // register read mux and master bit value
  always @* begin
    rd_nxt = 16'h0000;
    case (address_in)
      `A_CON:  rd_nxt = con_r & 16'hbfff;
      `A_STAT: rd_nxt = stat_r & 16'hc7ff;
      `A_RCV:  rd_nxt = {8'h00, rcv_r};
      `A_TRN:  rd_nxt = {8'h00, trn_r};
      `A_ADD:  rd_nxt = {6'h00, add_r};
      `A_BRG:  rd_nxt = {{(16-BRG_W){1'b0}}, brg_r};
      default: rd_nxt = 16'h0000;
    endcase
    case (m_st_r)
      M_TX:    m_bit = mbit_r[3] ? 1'b1 : trn_r[mix];
      M_ACK:   m_bit = con_r[`C_AKV]; // RL21
      default: m_bit = 1'b1;
    endcase
    sda_nxt = m_sda_r | s_ack_r |
              ((s_st_r == S_TX) & ~sbit_r[3] & ~trn_r[six]);
  end
  ////////////////////////////////////////////////////////////////
  // bus slave, pins and pad controls
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      waitrequest_out  <= 1'b1;
      readdata_out     <= 16'h0000;
      scl_out          <= 1'b0;
      sda_out          <= 1'b0;
      scl_oe_out       <= 1'b0;
      sda_oe_out       <= 1'b0;
      pins_owned_out   <= 1'b0;
      slew_disable_out <= 1'b0;
      smbus_level_out  <= 1'b0;
      scl_q_r          <= 1'b1;
      sda_q_r          <= 1'b1;
    end else begin
      waitrequest_out  <= ~((read_in | write_in) & waitrequest_out); // RL18
      if (read_in & waitrequest_out) begin
        readdata_out <= rd_nxt; // RL17
      end
      scl_out          <= 1'b0; // RL23
      sda_out          <= 1'b0;
      pins_owned_out   <= en; // RL1
      scl_oe_out       <= en & (m_scl_r |
                          (s_st_r != S_IDLE & ~con_r[`C_REL] & ~scl_in)); // RL3
      sda_oe_out       <= en & sda_nxt; // RL1
      slew_disable_out <= con_r[`C_SLW]; // RL8
      smbus_level_out  <= con_r[`C_SMB]; // RL9
      scl_q_r          <= scl_in; // RL23
      sda_q_r          <= sda_in;
    end
  end
  ////////////////////////////////////////////////////////////////
  // registers, master and slave engines
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      con_r        <= `CON_RST;
      stat_r       <= 16'h0000;
      rcv_r        <= 8'h00;
      trn_r        <= 8'h00;
      rsr_r        <= 8'h00;
      add_r        <= 10'h000;
      brg_r        <= {BRG_W{1'b0}};
      cnt_r        <= {BRG_W{1'b0}};
      m_st_r       <= M_IDLE;
      mph_r        <= 2'h0;
      mbit_r       <= 4'h0;
      m_own_r      <= 1'b0;
      m_scl_r      <= 1'b0;
      m_sda_r      <= 1'b0;
      s_st_r       <= S_IDLE;
      s_ph2_r      <= 1'b0;
      sbit_r       <= 4'h0;
      s_ack_r      <= 1'b0;
      rx_pulse_out <= 1'b0;
      gc_pulse_out <= 1'b0;
    end else begin
      rx_pulse_out <= 1'b0;
      gc_pulse_out <= 1'b0;
      // software side
      if (rd_do & (address_in == `A_RCV)) begin
        stat_r[`S_RBF] <= 1'b0; // RL22
      end
      if (wr_do) begin
        case (address_in)
          `A_CON: begin
            con_r <= writedata_in; // RL17
            if (!con_r[`C_STR]) begin
              con_r[`C_REL] <= con_r[`C_REL] | writedata_in[`C_REL]; // RL5
            end
          end
          `A_STAT: begin
            stat_r[`S_BCL] <= writedata_in[`S_BCL]; // RL17
            stat_r[`S_WCO] <= writedata_in[`S_WCO];
            stat_r[`S_OV]  <= writedata_in[`S_OV]; // RL24
          end
          `A_TRN: begin
            if (stat_r[`S_TBF] | m_busy) begin
              stat_r[`S_WCO] <= 1'b1;
            end else begin
              trn_r          <= writedata_in[7:0]; // RL19
              stat_r[`S_TBF] <= 1'b1; // RL22
              if (m_own_r & run) begin
                m_st_r         <= M_TX;
                mph_r          <= 2'h0;
                mbit_r         <= 4'h0;
                stat_r[`S_TRS] <= 1'b1;
              end
            end
          end
          `A_ADD:  add_r <= writedata_in[9:0];
          `A_BRG:  brg_r <= writedata_in[BRG_W-1:0];
          default: ;
        endcase
      end
      if (!en) begin
        m_st_r  <= M_IDLE; // RL1
        m_own_r <= 1'b0;
        m_scl_r <= 1'b0;
        m_sda_r <= 1'b0;
        s_st_r  <= S_IDLE;
        s_ack_r <= 1'b0;
      end else if (run) begin // RL2
        // bus condition monitor
        if (sta_det) begin
          stat_r[`S_S] <= 1'b1;
          stat_r[`S_P] <= 1'b0;
        end
        if (stp_det) begin
          stat_r[`S_P]   <= 1'b1;
          stat_r[`S_S]   <= 1'b0;
          stat_r[`S_GCS] <= 1'b0;
          stat_r[`S_A10] <= 1'b0;
        end
        // master request launch, start first
        if (m_st_r == M_IDLE) begin
          mph_r  <= 2'h0;
          mbit_r <= 4'h0;
          cnt_r  <= brg_r;
          if (con_r[`C_STA]) begin
            m_st_r <= M_STA; // RL20
          end else if (con_r[`C_RST]) begin
            m_st_r <= M_RST;
          end else if (con_r[`C_STP]) begin
            m_st_r <= M_STP;
          end else if (con_r[`C_RCE]) begin
            m_st_r <= M_RX;
          end else if (con_r[`C_AKE]) begin
            m_st_r <= M_ACK; // RL21
          end
        end else if (!tick | m_hold) begin
          cnt_r <= m_hold ? brg_r : cnt_r - 1'b1; // RL15
        end else begin
          cnt_r <= brg_r; // RL15
          case (m_st_r)
            M_STA: begin
              if (mph_r == 2'h0) begin
                if (~sda_in | ~scl_in) begin
                  stat_r[`S_BCL] <= 1'b1; // RL14
                  con_r[`C_STA]  <= 1'b0;
                  m_st_r         <= M_IDLE;
                end else begin
                  m_sda_r <= 1'b1;
                  mph_r   <= 2'h1;
                end
              end else begin
                m_scl_r       <= 1'b1;
                m_own_r       <= 1'b1;
                con_r[`C_STA] <= 1'b0; // RL20
                m_st_r        <= M_IDLE;
              end
            end
            M_RST, M_STP: begin
              mph_r <= mph_r + 2'h1;
              case (mph_r)
                2'h0: m_sda_r <= (m_st_r == M_STP);
                2'h1: m_scl_r <= 1'b0;
                2'h2: m_sda_r <= (m_st_r == M_RST);
                default: begin
                  m_st_r <= M_IDLE;
                  if (m_st_r == M_RST) begin
                    m_scl_r       <= 1'b1;
                    con_r[`C_RST] <= 1'b0; // RL20
                  end else begin
                    con_r[`C_STP] <= 1'b0; // RL20
                    m_own_r       <= 1'b0;
                    if (!sda_in) begin
                      stat_r[`S_BCL] <= 1'b1; // RL14
                    end
                  end
                end
              endcase
            end
            default: begin
              // one data bit: low+set, release, high+sample
              case (mph_r)
                2'h0: begin
                  m_sda_r <= ~m_bit; // RL23
                  mph_r   <= 2'h1;
                end
                2'h1: begin
                  m_scl_r <= 1'b0;
                  mph_r   <= 2'h2;
                end
                default: begin
                  m_scl_r <= 1'b1;
                  mph_r   <= 2'h0;
                  mbit_r  <= mbit_r + 4'h1; // RL16
                  if (m_st_r == M_TX & ~mbit_r[3] & m_bit & ~sda_in) begin
                    stat_r[`S_BCL] <= 1'b1; // RL14
                    stat_r[`S_TBF] <= 1'b0;
                    stat_r[`S_TRS] <= 1'b0;
                    m_st_r         <= M_IDLE;
                    m_own_r        <= 1'b0;
                    m_scl_r        <= 1'b0;
                    m_sda_r        <= 1'b0;
                  end else if (m_st_r == M_TX) begin
                    if (mbit_r[3]) begin
                      stat_r[`S_AKS] <= sda_in;
                      stat_r[`S_TBF] <= 1'b0; // RL22
                      stat_r[`S_TRS] <= 1'b0;
                      m_st_r         <= M_IDLE;
                    end
                  end else if (m_st_r == M_RX) begin
                    rsr_r <= {rsr_r[6:0], sda_in};
                    if (mbit_r == 4'h7) begin
                      con_r[`C_RCE] <= 1'b0;
                      m_st_r        <= M_IDLE;
                      rx_pulse_out  <= 1'b1; // RL12
                      if (stat_r[`S_RBF]) begin
                        stat_r[`S_OV] <= 1'b1; // RL24
                      end else begin
                        rcv_r          <= {rsr_r[6:0], sda_in}; // RL12
                        stat_r[`S_RBF] <= 1'b1; // RL22
                      end
                    end
                  end else begin
                    con_r[`C_AKE] <= 1'b0; // RL21
                    m_st_r        <= M_IDLE;
                  end
                end
              endcase
            end
          endcase
        end
        // slave engine
        if (!s_on | stp_det) begin
          s_st_r  <= S_IDLE;
          s_ack_r <= 1'b0;
        end else if (sta_det) begin
          s_st_r  <= S_ADR;
          s_ph2_r <= 1'b0;
          sbit_r  <= 4'h0;
          s_ack_r <= 1'b0;
        end else if (s_st_r != S_IDLE & rise) begin
          if (~sbit_r[3]) begin
            sbit_r <= sbit_r + 4'h1;
            if (s_st_r != S_TX) begin
              rsr_r <= {rsr_r[6:0], sda_in};
            end
          end else if (s_st_r == S_TX & sda_in) begin
            s_st_r <= S_IDLE; // nack ends slave tx
          end
        end else if (s_st_r != S_IDLE & fall) begin
          if (sbit_r == 4'h8) begin
            sbit_r <= 4'h9;
            case (s_st_r)
              S_ADR: begin
                stat_r[`S_DA] <= 1'b0;
                if (s_ph2_r) begin
                  s_ack_r <= (b == add_r[7:0]); // RL13
                  s_st_r  <= (b == add_r[7:0]) ? S_RX : S_IDLE;
                  stat_r[`S_A10] <= (b == add_r[7:0]);
                end else if (con_r[`C_ALL]) begin
                  s_ack_r        <= 1'b1; // RL6
                  s_st_r         <= b[0] ? S_TX : S_RX;
                  stat_r[`S_RW]  <= b[0];
                end else if (gc_hit) begin
                  s_ack_r        <= 1'b1; // RL10
                  s_st_r         <= S_RX;
                  stat_r[`S_GCS] <= 1'b1;
                  gc_pulse_out   <= 1'b1; // RL10
                end else if (con_r[`C_TEN]) begin
                  s_ack_r <= hdr_hit & (~b[0] | stat_r[`S_A10]); // RL7
                  s_ph2_r <= ~b[0];
                  s_st_r  <= ~(hdr_hit & (~b[0] | stat_r[`S_A10])) ? S_IDLE :
                             (b[0] ? S_TX : S_ADR);
                  stat_r[`S_RW] <= b[0];
                end else begin
                  s_ack_r <= (b[7:1] == add_r[6:0]); // RL7
                  s_st_r  <= (b[7:1] != add_r[6:0]) ? S_IDLE :
                             (b[0] ? S_TX : S_RX);
                  stat_r[`S_RW] <= b[0];
                end
              end
              S_RX: begin
                stat_r[`S_DA] <= 1'b1;
                rx_pulse_out  <= 1'b1; // RL12
                s_ack_r       <= ~stat_r[`S_RBF];
                if (stat_r[`S_RBF]) begin
                  stat_r[`S_OV] <= 1'b1; // RL24
                end else begin
                  rcv_r          <= b; // RL12
                  stat_r[`S_RBF] <= 1'b1; // RL22
                end
                if (con_r[`C_STR]) begin
                  con_r[`C_REL] <= 1'b0; // RL4 RL11
                end
              end
              default: stat_r[`S_TBF] <= 1'b0; // RL22
            endcase
          end else if (sbit_r == 4'h9) begin
            sbit_r  <= 4'h0;
            s_ack_r <= 1'b0;
            if (s_st_r == S_TX) begin
              con_r[`C_REL] <= 1'b0; // RL4 RL5
            end
          end
        end
      end
    end
  end
endmodule

// [verif/i2c_master_slave_port_checker.sv]
// assertions on the pins of the two-wire bus port
`timescale 1ns/1ps
`include "i2c_port_defines.vh"
module i2c_master_slave_port_checker (
  input wire        sys_clk_in,
  input wire        reset_n_in,
  input wire [2:0]  address_in,
  input wire        read_in,
  input wire        write_in,
  input wire [15:0] writedata_in,
  input wire [15:0] readdata_out,
  input wire        waitrequest_out,
  input wire        idle_mode_in,
  input wire        scl_out,
  input wire        scl_oe_out,
  input wire        sda_out,
  input wire        sda_oe_out,
  input wire        pins_owned_out,
  input wire        slew_disable_out,
  input wire        rx_pulse_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // last written enable, stop-in-idle and slew bits
  reg  [2:0] cfg_r;
  wire       con_wr;
  assign con_wr = write_in && !waitrequest_out && address_in == `A_CON;
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      cfg_r <= 3'h0;
    else if (con_wr)
      cfg_r <= {writedata_in[`C_EN], writedata_in[`C_SIDL], writedata_in[`C_SLW]};
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////////////////////
  property p_wait_answer;
    (read_in || write_in) && waitrequest_out |=> !waitrequest_out;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("request not answered");
  property p_wait_one;
    !waitrequest_out |=> waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_unmapped;
    read_in && !waitrequest_out && address_in[2:1] == 2'b11 |-> readdata_out == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_open_drain;
    scl_out == 1'b0 && sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_pins;
    $stable(cfg_r) [*2] |-> pins_owned_out == cfg_r[2];
  endproperty
  a_pins: assert property (p_pins) else $error("pin ownership wrong");
  property p_slew;
    $stable(cfg_r) [*2] |-> slew_disable_out == cfg_r[0];
  endproperty
  a_slew: assert property (p_slew) else $error("slew output wrong");
  property p_released;
    !pins_owned_out [*2] |-> !scl_oe_out && !sda_oe_out;
  endproperty
  a_released: assert property (p_released) else $error("disabled block pulls a line");
  property p_rx_pulse;
    rx_pulse_out |=> !rx_pulse_out;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("receive pulse too long");
  property p_idle_freeze;
    (cfg_r[1] && idle_mode_in && $stable(cfg_r)) [*2] |-> $stable(scl_oe_out) && $stable(sda_oe_out);
  endproperty
  a_idle_freeze: assert property (p_idle_freeze) else $error("lines moved in idle");
endmodule

// [verif/i2c_bus_partner.sv]
// behavioural slave on the shared two-wire bus
`timescale 1ns/1ps
module i2c_bus_partner #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       hog_in,
  input  wire logic [7:0] tx_byte_in,
  output wire logic       sda_pull_out,
  output logic      [7:0] rx_byte_out
);
  logic [3:0] bit_n;
  logic [7:0] shift;
  logic       sel;
  logic       rd;
  logic       first;
  logic       drv;
  initial begin
    bit_n = 4'h0;
    shift = 8'h00;
    sel = 1'b0;
    rd = 1'b0;
    first = 1'b0;
    drv = 1'b0;
    rx_byte_out = 8'h00;
  end
  // hog holds data low to force a collision
  assign sda_pull_out = hog_in || drv;
  always @(negedge sda_in) begin
    if (scl_in) begin
      bit_n = 4'h0;
      first = 1'b1;
    end
  end
  always @(posedge sda_in) begin
    if (scl_in) begin
      sel = 1'b0;
      first = 1'b0;
    end
  end
  // a nack from the master ends a read
  always @(posedge scl_in) begin
    if (bit_n < 4'h8)
      shift = {shift[6:0], sda_in};
    else if (rd && sda_in)
      sel = 1'b0;
    bit_n = bit_n + 4'h1;
  end
  always @(negedge scl_in) begin
    drv = 1'b0;
    if (bit_n == 4'h9)
      bit_n = 4'h0;
    if (bit_n == 4'h8) begin
      if (first) begin
        sel = (shift[7:1] == ADDR);
        rd = shift[0];
        drv = sel;
      end else if (sel && !rd) begin
        rx_byte_out = shift;
        drv = 1'b1;
      end
      first = 1'b0;
    end else if (sel && rd && !first) begin
      drv = !tx_byte_in[3'd7 - bit_n[2:0]];
    end
  end
endmodule

// [verif/i2c_master_slave_port_test.sv]
// self-checking bench for the two-wire bus port
`timescale 1ns/1ps
`include "i2c_port_defines.vh"
module i2c_master_slave_port_test;
  localparam logic [6:0] SLV = 7'h2a;
  logic        sys_clk_in, reset_n_in, read_in, write_in, idle_mode_in;
  logic [2:0]  address_in;
  logic [15:0] writedata_in, readdata_out, q;
  logic        waitrequest_out, scl_out, scl_oe_out, sda_out, sda_oe_out;
  logic        pins_owned_out, slew_disable_out, smbus_level_out, rx_pulse_out, gc_pulse_out;
  logic        hog, stretch, sda_pull, scl_line, sda_line;
  logic [7:0]  tx_byte, rx_byte;
  int          bad_count, total_checks, pulses;
  // wired-and lines with pull-ups
  assign scl_line = !(scl_oe_out || stretch);
  assign sda_line = !(sda_oe_out || sda_pull);
  i2c_master_slave_port #(.BRG_W(9)) u_i2c_master_slave_port (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .idle_mode_in(idle_mode_in), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .pins_owned_out(pins_owned_out), .slew_disable_out(slew_disable_out),
    .smbus_level_out(smbus_level_out), .rx_pulse_out(rx_pulse_out),
    .gc_pulse_out(gc_pulse_out));
  i2c_bus_partner #(.ADDR(SLV)) u_i2c_bus_partner (.scl_in(scl_line), .sda_in(sda_line),
    .hog_in(hog), .tx_byte_in(tx_byte), .sda_pull_out(sda_pull), .rx_byte_out(rx_byte));
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    if (rx_pulse_out === 1'b1)
      pulses++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    address_in <= a;
    writedata_in <= d;
    write_in <= w;
    read_in <= !w;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 50);
    chk(16'(n < 50), 16'h0001, "no bus answer");
    q = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rc(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e,
                    input string s);
    acc(1'b0, a, 16'h0000);
    chk(q & m, e, s);
  endtask
  task automatic poll(input logic [2:0] a, input logic [15:0] m);
    int n;
    n = 0;
    do begin
      acc(1'b0, a, 16'h0000);
      n++;
    end while ((q & m) != 16'h0000 && n < 400);
    chk(q & m, 16'h0000, "sequence stuck");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n_in = 1'b0;
    read_in = 1'b0;
    write_in = 1'b0;
    address_in = 3'h0;
    writedata_in = 16'h0000;
    idle_mode_in = 1'b0;
    hog = 1'b0;
    stretch = 1'b0;
    tx_byte = 8'h3c;
    bad_count = 0;
    total_checks = 0;
    pulses = 0;
    repeat (20) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    rc(`A_CON, 16'hffff, 16'h1000, "control reset");
    rc(`A_STAT, 16'hffff, 16'h0000, "status reset");
    wr(3'h6, 16'hffff);
    rc(3'h6, 16'hffff, 16'h0000, "unmapped read");
    wr(`A_CON, 16'hafc0);
    rc(`A_CON, 16'hffff, 16'hbfc0, "control readback");
    chk(pins_owned_out, 1'b1, "pins not owned");
    chk(slew_disable_out, 1'b1, "slew output");
    chk(smbus_level_out, 1'b1, "level output");
    wr(`A_CON, 16'h1000);
    wr(`A_CON, 16'h0000);
    rc(`A_CON, 16'hffff, 16'h1000, "release cleared by software");
    chk(pins_owned_out, 1'b0, "pins still owned");
    wr(`A_STAT, 16'hffff);
    rc(`A_STAT, 16'h003f, 16'h0000, "status low bits written");
    wr(`A_STAT, 16'h0000);
    wr(`A_ADD, 16'hffff);
    rc(`A_ADD, 16'hffff, 16'h03ff, "own address width");
    wr(`A_BRG, 16'hffff);
    rc(`A_BRG, 16'hffff, 16'h01ff, "baud width");
    wr(`A_BRG, 16'h0002);
    // master write with a clock stretch
    wr(`A_CON, 16'h9001);
    poll(`A_CON, 16'h0001);
    rc(`A_STAT, 16'h0018, 16'h0008, "start not seen");
    wr(`A_TRN, {8'h00, SLV, 1'b0});
    rc(`A_STAT, 16'h0001, 16'h0001, "tx not full");
    wr(`A_TRN, 16'h0011);
    rc(`A_STAT, 16'h0080, 16'h0080, "no write collision");
    wr(`A_STAT, 16'h0000);
    poll(`A_STAT, 16'h4001);
    rc(`A_STAT, 16'h8000, 16'h0000, "address nacked");
    wr(`A_TRN, 16'h00a5);
    do @(posedge sys_clk_in); while (scl_oe_out !== 1'b0);
    do @(posedge sys_clk_in); while (scl_oe_out !== 1'b1);
    stretch <= 1'b1;
    repeat (120) @(posedge sys_clk_in);
    rc(`A_STAT, 16'h4000, 16'h4000, "ran through stretch");
    stretch <= 1'b0;
    poll(`A_STAT, 16'h4001);
    chk({8'h00, rx_byte}, 16'h00a5, "byte not sent");
    // restart and read two bytes, second overflows
    wr(`A_CON, 16'h9002);
    poll(`A_CON, 16'h0002);
    wr(`A_TRN, {8'h00, SLV, 1'b1});
    poll(`A_STAT, 16'h4001);
    wr(`A_CON, 16'h9008);
    poll(`A_CON, 16'h0008);
    rc(`A_STAT, 16'h0002, 16'h0002, "rx not full");
    chk(16'(pulses), 16'h0001, "receive pulse count");
    tx_byte <= 8'hc3;
    wr(`A_CON, 16'h9010);
    poll(`A_CON, 16'h0010);
    wr(`A_CON, 16'h9008);
    poll(`A_CON, 16'h0008);
    rc(`A_STAT, 16'h0042, 16'h0042, "no overflow");
    rc(`A_RCV, 16'h00ff, 16'h003c, "old byte lost");
    rc(`A_STAT, 16'h0002, 16'h0000, "rx full after read");
    wr(`A_CON, 16'h9030);
    poll(`A_CON, 16'h0010);
    wr(`A_CON, 16'h9004);
    poll(`A_CON, 16'h0004);
    rc(`A_STAT, 16'h0018, 16'h0010, "stop not seen");
    // start against a held data line
    wr(`A_STAT, 16'h0000);
    hog <= 1'b1;
    wr(`A_CON, 16'h9001);
    poll(`A_CON, 16'h0001);
    rc(`A_STAT, 16'h0400, 16'h0400, "no collision");
    hog <= 1'b0;
    wr(`A_STAT, 16'h0000);
    // start request frozen while idle
    wr(`A_CON, 16'hb000);
    idle_mode_in <= 1'b1;
    wr(`A_CON, 16'hb001);
    repeat (50) @(posedge sys_clk_in);
    rc(`A_CON, 16'h0001, 16'h0001, "ran in idle");
    idle_mode_in <= 1'b0;
    poll(`A_CON, 16'h0001);
    wr(`A_CON, 16'hb004);
    poll(`A_CON, 16'h0004);
    wr(`A_CON, 16'h0000);
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge sys_clk_in);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
endmodule
bind i2c_master_slave_port i2c_master_slave_port_checker u_i2c_master_slave_port_checker (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .address_in(address_in),
  .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
  .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
  .idle_mode_in(idle_mode_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .pins_owned_out(pins_owned_out),
  .slew_disable_out(slew_disable_out), .rx_pulse_out(rx_pulse_out));
